// ---- src/mrs_run_select.sv ----
// Run control, data-set selection and brake sequencing with an APB register file
// Assumes pins asynchronous to pclk and an APB master that holds each request
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "mrs_defines.svh"
module mrs_run_select
  import mrs_pkg::*;
#(
  parameter int TICK_CYC = `MRS_CLK_HZ / 1000 * `MRS_TICK_MS,
  parameter int UNIT_CYC = `MRS_CLK_HZ / 1000 * `MRS_UNIT_MS
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        data_select_bit0,
  input  wire logic        data_select_bit1,
  input  wire logic        brake_free_input,
  // Drive outputs
  output logic             motor_on,
  output logic             dir_cw,
  output logic      [15:0] speed_cmd,
  output logic             brake_release,
  output logic             stop_braking,
  output logic             stop_hold
);
  // ---------------------------------------------------------------
  // Constants and declarations
  // ---------------------------------------------------------------
  localparam logic [9:0] HOLD_T  = 10'(`MRS_HOLD_MS / `MRS_TICK_MS);
  localparam logic [9:0] INST_T  = 10'(`MRS_INST_MS / `MRS_TICK_MS);
  localparam int         RECOG_T = `MRS_RECOG_MS / `MRS_TICK_MS;

  mrs_state_t  state_q;
  mrs_state_t  state_d;
  logic [23:0] tdiv_q;
  logic        tick_q;
  logic [9:0]  cnt_q;
  logic [3:0]  ctrl_q;
  logic [15:0] remote_q;
  logic [15:0] spd_set_q [4];
  logic [15:0] tim_q [4];
  logic        start_fwd_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        motor_on_q;
  logic        dir_cw_q;
  logic        brake_rel_q;
  logic        braking_q;
  logic        hold_q;
  logic [4:0]  filt_w;
  logic [15:0] speed_w;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] mrs_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // ---------------------------------------------------------------
  // Time base and input filter
  // ---------------------------------------------------------------
  // One-cycle millisecond tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tdiv_q <= 24'h000000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= tdiv_q == 24'(TICK_CYC - 1);
      tdiv_q <= (tdiv_q == 24'(TICK_CYC - 1)) ? 24'h000000 : tdiv_q + 24'h000001;
    end
  end

  // Synchronised and stable pin levels
  mrs_debounce #(
    .W   (5),
    .CNT (RECOG_T)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_q),
    .raw     ({brake_free_input, data_select_bit1, data_select_bit0,
                reverse_run_input, forward_run_input}),
    .filt    (filt_w)
  );

  // Named pin levels and run decode
  wire       fwd_f        = filt_w[0];
  wire       rev_f        = filt_w[1];
  wire [1:0] data_no_w    = filt_w[3:2];
  wire       free_f       = filt_w[4];
  wire       run_one_w    = fwd_f ^ rev_f;
  wire       both_w       = fwd_f & rev_f;
  wire       start_held_w = start_fwd_q ? fwd_f : rev_f;

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  // Address decode; data sets are pairs of words in one page
  wire       hit_ctrl_w   = paddr == `MRS_OFS_CTRL;
  wire       hit_remote_w = paddr == `MRS_OFS_REMOTE;
  wire       hit_status_w = paddr == `MRS_OFS_STATUS;
  wire       hit_data_w   = paddr[11:5] == `MRS_DATA_PAGE && paddr[1:0] == 2'h0;
  wire [1:0] set_w        = paddr[4:3];
  wire       hi_w         = paddr[2];
  wire       map_w        = hit_ctrl_w | hit_remote_w | hit_status_w | hit_data_w;
  wire       wr_w         = psel & penable & pwrite & pready_q;

  // Status word: sequencer state, selected set, present speed
  wire [31:0] status_w = {speed_w, 10'h000, data_no_w, 1'b0, state_q};

  // Read selection
  wire [15:0] data_rd_w = hi_w ? tim_q[set_w] : spd_set_q[set_w];
  wire [31:0] rd_w = hit_ctrl_w   ? {28'h0000000, ctrl_q} :
                     hit_remote_w ? {16'h0000, remote_q} :
                     hit_status_w ? status_w :
                     hit_data_w   ? {16'h0000, data_rd_w} : 32'h00000000;

  // Write data after byte-lane merge
  wire [31:0] ctrl_wr_w   = mrs_merge({28'h0000000, ctrl_q}, pwdata, pstrb);
  wire [31:0] remote_wr_w = mrs_merge({16'h0000, remote_q}, pwdata, pstrb);
  wire [31:0] data_wr_w   = mrs_merge({16'h0000, data_rd_w}, pwdata, pstrb);

  // Answer in the access cycle: read data and error loaded at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~map_w;
      if (psel && !penable) prdata_q <= pwrite ? 32'h00000000 : rd_w;
    end
  end

  // Control and remote speed registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= `MRS_CTRL_RST;
      remote_q <= 16'h0000;
    end
    else
    begin
      if (wr_w && hit_ctrl_w) ctrl_q <= ctrl_wr_w[3:0];
      if (wr_w && hit_remote_w) remote_q <= remote_wr_w[15:0];
    end
  end

  // Operation data sets: speed word and ramp-time word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        spd_set_q[i] <= `MRS_SPEED_RST;
        tim_q[i]     <= {`MRS_TIME_RST, `MRS_TIME_RST};
      end
    end
    else if (wr_w && hit_data_w)
    begin
      if (hi_w) tim_q[set_w] <= data_wr_w[15:0];
      else spd_set_q[set_w] <= data_wr_w[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Speed selection and ramp
  // ---------------------------------------------------------------
  // Set 0 may follow the remote command; other sets use stored speeds
  wire        remote_w = ctrl_q[`MRS_CTRL_EXT] && data_no_w == 2'h0;
  wire [15:0] tgt_w    = remote_w ? remote_q : spd_set_q[data_no_w];
  wire [15:0] tim_w    = tim_q[data_no_w];
  wire [15:0] ramp_tgt_w = (state_q == ST_RUN) ? tgt_w : 16'h0000;
  wire        zero_w   = state_q == ST_IDLE || state_q == ST_INST;

  // Ramp toward the running target, or to zero in a deceleration stop
  mrs_ramp #(
    .UNIT_CYC (UNIT_CYC)
  ) u_ramp (
    .pclk    (pclk),
    .presetn (presetn),
    .target  (ramp_tgt_w),
    .acc_t   (tim_w[7:0]),
    .dec_t   (tim_w[15:8]),
    .remote  (remote_w),
    .zero    (zero_w),
    .speed   (speed_w)
  );

  // ---------------------------------------------------------------
  // Run sequencer
  // ---------------------------------------------------------------
  // Next state from run inputs, speed and stop timers
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (run_one_w) state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (both_w) state_d = ST_INST;
        else if (!start_held_w)
          state_d = ctrl_q[`MRS_CTRL_COAST] ? ST_IDLE : ST_DECEL;
      end
      ST_DECEL:
      begin
        if (both_w) state_d = ST_INST;
        else if (speed_w == 16'h0000)
          state_d = ctrl_q[`MRS_CTRL_DECEL] ? ST_HOLD : ST_IDLE;
      end
      ST_HOLD:
      begin
        if (tick_q && cnt_q == HOLD_T - 10'h001) state_d = ST_IDLE;
      end
      ST_INST:
      begin
        if (tick_q && cnt_q == INST_T - 10'h001) state_d = ST_IDLE;
      end
    endcase
  end

  // State, stop timer and start latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 10'h000;
      start_fwd_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q) cnt_q <= 10'h000;
      else if (tick_q) cnt_q <= cnt_q + 10'h001;
      if (state_q == ST_IDLE && run_one_w) start_fwd_q <= fwd_f;
    end
  end

  // ---------------------------------------------------------------
  // Drive outputs
  // ---------------------------------------------------------------
  // Outputs follow the next state so they line up with state_q
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      motor_on_q  <= 1'b0;
      dir_cw_q    <= 1'b0;
      brake_rel_q <= 1'b0;
      braking_q   <= 1'b0;
      hold_q      <= 1'b0;
    end
    else
    begin
      motor_on_q  <= state_d inside {ST_RUN, ST_DECEL, ST_HOLD};
      brake_rel_q <= (state_d inside {ST_RUN, ST_DECEL}) | free_f;
      braking_q   <= state_d == ST_INST;
      hold_q      <= state_d == ST_HOLD;
      if (state_q == ST_IDLE && run_one_w)
        dir_cw_q <= fwd_f ^ ctrl_q[`MRS_CTRL_SWAP];
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign motor_on      = motor_on_q;
  assign dir_cw        = dir_cw_q;
  assign speed_cmd     = speed_w;
  assign brake_release = brake_rel_q;
  assign stop_braking  = braking_q;
  assign stop_hold     = hold_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycles spent in the current stop phase
  logic [31:0] dur_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) dur_q <= 32'h00000000;
    else if (hold_q || braking_q) dur_q <= dur_q + 32'h00000001;
    else dur_q <= 32'h00000000;
  end

  // Run input released while running, with no instant-stop condition
  sequence run_dropped_s;
    state_q == ST_RUN && !start_held_w && !both_w;
  endsequence

  // Sequencer at rest in the cycle a start decision is taken
  sequence started_s;
    state_q == ST_IDLE && run_one_w;
  endsequence

  dir_select_a: assert property (started_s |=>
    dir_cw_q == ($past(fwd_f) ^ $past(ctrl_q[`MRS_CTRL_SWAP])) && motor_on_q)
    else $error("run direction does not match input and swap bit");
  hold_enable_a: assert property (
    state_q == ST_DECEL && speed_w == 16'h0000 && !both_w
    |=> hold_q == $past(ctrl_q[`MRS_CTRL_DECEL]))
    else $error("brake hold does not follow deceleration control");
  hold_len_a: assert property ($fell(hold_q) && !braking_q |->
    dur_q >= 32'(HOLD_T - 10'h001) * 32'(TICK_CYC) && dur_q <= 32'(HOLD_T) * 32'(TICK_CYC))
    else $error("brake hold length is not 0.1 s");
  inst_len_a: assert property ($fell(braking_q) |->
    dur_q >= 32'(INST_T - 10'h001) * 32'(TICK_CYC) && dur_q <= 32'(INST_T) * 32'(TICK_CYC))
    else $error("braking phase length is not 0.4 s");
  free_release_a: assert property (free_f |=> brake_release)
    else $error("brake not released while free input is on");
  both_inst_a: assert property (
    state_q inside {ST_RUN, ST_DECEL} && both_w |=> braking_q ##1 speed_w == 16'h0000)
    else $error("both run inputs did not give an instant stop");
  drop_stop_a: assert property (run_dropped_s |=>
    state_q == ($past(ctrl_q[`MRS_CTRL_COAST]) ? ST_IDLE : ST_DECEL) && brake_rel_q == $past(free_f)
    || !$past(ctrl_q[`MRS_CTRL_COAST]) && state_q == ST_DECEL)
    else $error("dropped run input did not stop the motor");
  sel_run_a: assert property (
    state_q == ST_RUN && start_held_w && !both_w |=> state_q == ST_RUN && motor_on_q)
    else $error("run dropped although run input held");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not given in the access cycle");
endmodule

// ---- include/mrs_defines.svh ----
// Constants for the motor run and speed-select block
// Assumes inclusion ahead of mrs_pkg and every design module of the block
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH
// Clock and timing, times in ms as printed
`define MRS_CLK_HZ       10000000
`define MRS_TICK_MS      1
`define MRS_RECOG_MS     10
`define MRS_HOLD_MS      100
`define MRS_INST_MS      400
`define MRS_UNIT_MS      100
`define MRS_REMOTE_RPM   16'h03e8
// APB byte offsets and data-set page number
`define MRS_OFS_CTRL     12'h000
`define MRS_OFS_REMOTE   12'h004
`define MRS_OFS_STATUS   12'h008
`define MRS_DATA_PAGE    7'h01
// Control bit positions and reset values
`define MRS_CTRL_EXT     0
`define MRS_CTRL_SWAP    1
`define MRS_CTRL_DECEL   2
`define MRS_CTRL_COAST   3
`define MRS_CTRL_RST     4'h4
`define MRS_SPEED_RST    16'h012c
`define MRS_TIME_RST     8'h05
`endif

// ---- include/mrs_pkg.sv ----
// Types of the motor run and speed-select block
// Assumes mrs_defines.svh supplies the numeric constants
package mrs_pkg;
  // Run sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_HOLD, ST_INST} mrs_state_t;
endpackage

// ---- src/mrs_debounce.sv ----
// Input synchroniser and stability filter for the run and select pins
// Assumes a one-cycle tick enable from the top-level divider
`timescale 1ns/10ps
module mrs_debounce
  import mrs_pkg::*;
#(
  parameter int W   = 5,
  parameter int CNT = 10
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Tick and raw pins
  input  wire logic         tick,
  input  wire logic [W-1:0] raw,
  // Accepted levels
  output logic      [W-1:0] filt
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] filt_q;
  logic [7:0]   cnt_q [W];

  assign filt = filt_q;

  // Two-flop synchroniser, then a per-bit stability count in ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      filt_q <= '0;
      for (int i = 0; i < W; i++) cnt_q[i] <= 8'h00;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == filt_q[i]) cnt_q[i] <= 8'h00;
        else if (tick && cnt_q[i] == 8'(CNT - 1))
        begin
          filt_q[i] <= s2_q[i];
          cnt_q[i]  <= 8'h00;
        end
        else if (tick) cnt_q[i] <= cnt_q[i] + 8'h01;
      end
    end
  end

  // A level is taken only after the full count of stable ticks
  for (genvar g = 0; g < W; g++)
  begin : g_chk
    stable_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(filt_q[g]) |-> $past(tick) && $past(cnt_q[g]) == 8'(CNT - 1))
      else $error("input level taken before recognition time");
  end
endmodule

// ---- src/mrs_ramp.sv ----
// Speed ramp generator: one r/min steps paced by a phase accumulator
// Assumes ramp times in tenths of a second and a fixed clock rate
`timescale 1ns/10ps
`include "mrs_defines.svh"
module mrs_ramp
  import mrs_pkg::*;
#(
  parameter int UNIT_CYC = 1000000
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Target and ramp times
  input  wire logic [15:0] target,
  input  wire logic [7:0]  acc_t,
  input  wire logic [7:0]  dec_t,
  input  wire logic        remote,
  input  wire logic        zero,
  // Present speed
  output logic      [15:0] speed
);
  logic [15:0] spd_q;
  logic [15:0] tgt_q;
  logic [15:0] span_q;
  logic [27:0] acc_q;

  // Step pacing: span r/min spread over the selected time
  wire        up_w     = target > spd_q;
  wire [7:0]  t_w      = up_w ? acc_t : dec_t;
  wire [27:0] thr_w    = 28'(t_w) * 28'(UNIT_CYC);
  wire [15:0] diff_w   = up_w ? target - spd_q : spd_q - target;
  wire        reload_w = target != tgt_q;
  wire [27:0] sum_w    = acc_q + 28'(span_q);
  wire        step_w   = !reload_w && spd_q != target && sum_w >= thr_w;

  assign speed = spd_q;

  // Span reload on a new target, then stepping toward it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spd_q  <= 16'h0000;
      tgt_q  <= 16'h0000;
      span_q <= 16'h0000;
      acc_q  <= 28'h0000000;
    end
    else if (zero)
    begin
      spd_q <= 16'h0000;
      tgt_q <= 16'h0000;
      acc_q <= 28'h0000000;
    end
    else if (reload_w)
    begin
      tgt_q  <= target;
      span_q <= remote ? `MRS_REMOTE_RPM : diff_w;
      acc_q  <= 28'h0000000;
    end
    else if (step_w)
    begin
      spd_q <= up_w ? spd_q + 16'h0001 : spd_q - 16'h0001;
      acc_q <= sum_w - thr_w;
    end
    else if (spd_q != target) acc_q <= sum_w;
  end

  remote_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    reload_w && !zero && remote |=> span_q == `MRS_REMOTE_RPM)
    else $error("remote span is not 1000 r/min");
  panel_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    reload_w && !zero && !remote |=> span_q == $past(diff_w))
    else $error("panel span differs from present-to-target distance");
  toward_target_a: assert property (@(posedge pclk) disable iff (!presetn)
    !zero && spd_q < target |=> spd_q == $past(spd_q) || spd_q == $past(spd_q) + 16'h0001)
    else $error("speed does not move toward target in single steps");
endmodule

// ---- verif/mrs_switch_model.sv ----
// Switch-panel model: run, select and brake-free contacts
// Assumes the bench requests levels; each accepted level stands a minimum time
`timescale 1ns/10ps
module mrs_switch_model
#(
  parameter int HOLD_CYC = 110
)
(
  // Clock
  input  wire logic       pclk,
  // Requested contact levels {free, sel1, sel0, rev, fwd}
  input  wire logic [4:0] req,
  // Contact outputs
  output logic      [4:0] pins
);
  int held_q = HOLD_CYC;

  // Contacts are plain levels; a change waits until the old level has stood
  initial pins = 5'h00;
  always @(posedge pclk)
  begin
    if (req !== pins && held_q >= HOLD_CYC)
    begin
      pins   <= req;
      held_q <= 0;
    end
    else
      held_q <= held_q + 1;
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the run and speed-select block
// Assumes short tick and unit parameters; a switch model drives the pins
`timescale 1ns/10ps
`include "mrs_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(nm, c, m) begin wk = 0; while (!(c) && wk < (m)) begin @(negedge pclk); \
  wk++; end if (!(c)) begin n_mismatch++; $display("ERROR %s expected 1 seen 0", nm); \
  stop_test(); end end
module testbench;
  import mrs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [4:0]  req, pins;
  logic        motor_on, dir_cw, brake_release, stop_braking, stop_hold, hold_seen;
  logic [15:0] speed_cmd;
  int          n_mismatch, check_count, wk, seed, s;
  int          spd [4];

  // Device under test and its contact panel
  mrs_run_select #(.TICK_CYC(10), .UNIT_CYC(100)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .forward_run_input(pins[0]), .reverse_run_input(pins[1]), .data_select_bit0(pins[2]),
    .data_select_bit1(pins[3]), .brake_free_input(pins[4]), .motor_on(motor_on),
    .dir_cw(dir_cw), .speed_cmd(speed_cmd), .brake_release(brake_release),
    .stop_braking(stop_braking), .stop_hold(stop_hold));
  mrs_switch_model sw_u (.pclk(pclk), .req(req), .pins(pins));

  // Clock and hold-phase monitor
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (stop_hold === 1'b1) hold_seen <= 1'b1;

  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer; read data and error kept in rd and err
  // Request held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    `WAITC("pready", pready === 1'b1, 0)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [4:0] r);
    @(posedge pclk);
    req <= r;
  endtask

  function automatic logic [11:0] sa(input int n, input int t);
    return 12'(32'h20 + 8 * n + 4 * t);
  endfunction

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen running");
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'hd60a0b9a; n_mismatch = 0; check_count = 0; hold_seen = 1'b0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hf; req = 5'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped access, random speeds per set
    apb(1'b0, `MRS_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h4, rd)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK("unmapped", 1'b1, err)
    for (s = 0; s < 4; s++)
    begin
      apb(1'b0, sa(s, 0), 32'h0);
      `CHK("speed_rst", 32'h12c, rd)
      apb(1'b0, sa(s, 1), 32'h0);
      `CHK("time_rst", 32'h505, rd)
      // Distinct speeds per set, all inside the operator's range
      spd[s] = 300 + 128 * s + ($random(seed) & 127);
      apb(1'b1, sa(s, 0), spd[s]);
      apb(1'b1, sa(s, 1), 32'h202);
      apb(1'b0, sa(s, 0), 32'h0);
      `CHK("speed_wr", spd[s], rd)
    end
    // Forward run stepping through every set without stopping
    for (int k = 1; k < 5; k++)
    begin
      s = k % 4;
      go({1'b0, 2'(s), 2'b01});
      `WAITC("speed", speed_cmd === 16'(spd[s]), 1500)
      apb(1'b0, `MRS_OFS_STATUS, 32'h0);
      `CHK("set_no", 2'(s), rd[5:4])
      `CHK("running", 1'b1, motor_on)
      `CHK("dir_fwd", 1'b1, dir_cw)
      `CHK("brake_off", 1'b1, brake_release)
    end
    // Deceleration stop with brake hold
    go(5'h00);
    `WAITC("hold_on", stop_hold === 1'b1, 3000)
    `CHK("decel_zero", 16'h0, speed_cmd)
    `WAITC("hold_off", stop_hold === 1'b0, 1200)
    `CHK("hold_len", 1'b1, (wk >= 985 && wk <= 1015))
    // Reverse, then forward with direction swap
    go(5'h02);
    `WAITC("rev_on", motor_on === 1'b1, 400)
    `CHK("dir_rev", 1'b0, dir_cw)
    go(5'h00);
    `WAITC("rev_off", motor_on === 1'b0, 5000)
    apb(1'b1, `MRS_OFS_CTRL, 32'h6);
    go(5'h01);
    `WAITC("swap_on", motor_on === 1'b1, 400)
    `CHK("dir_swap", 1'b0, dir_cw)
    // Both run pins: instant stop, no restart while both stay on
    go(5'h03);
    `WAITC("inst_on", stop_braking === 1'b1, 400)
    // Speed is cleared one cycle after the braking phase starts
    @(negedge pclk);
    `CHK("inst_zero", 16'h0, speed_cmd)
    `WAITC("inst_off", stop_braking === 1'b0, 4200)
    `CHK("inst_len", 1'b1, (wk >= 3985 && wk <= 4015))
    repeat (200) @(negedge pclk);
    `CHK("no_start", 1'b0, motor_on)
    // Deceleration control off: no brake hold
    apb(1'b1, `MRS_OFS_CTRL, 32'h0);
    go(5'h00);
    go(5'h01);
    `WAITC("nd_on", motor_on === 1'b1, 600)
    hold_seen <= 1'b0;
    go(5'h00);
    `WAITC("nd_off", motor_on === 1'b0, 3000)
    `CHK("no_hold", 1'b0, hold_seen)
    // Coasting stop
    apb(1'b1, `MRS_OFS_CTRL, 32'hc);
    go(5'h01);
    `WAITC("co_on", motor_on === 1'b1, 400)
    go(5'h00);
    `WAITC("co_off", motor_on === 1'b0, 250)
    // Speed is cleared one cycle after the sequencer reaches idle
    @(negedge pclk);
    `CHK("coast", 16'h0, speed_cmd)
    // Remote speed on set 0: ramp scaled to 1000 r/min, then panel ramp
    apb(1'b1, `MRS_OFS_CTRL, 32'h5);
    apb(1'b1, `MRS_OFS_REMOTE, 32'd500);
    apb(1'b1, sa(0, 1), 32'ha0a);
    go(5'h01);
    `WAITC("rm_on", motor_on === 1'b1, 400)
    `WAITC("rm_spd", speed_cmd === 16'd500, 2000)
    `CHK("rm_ramp", 1'b1, (wk >= 490 && wk <= 515))
    go(5'h00);
    `WAITC("rm_off", motor_on === 1'b0, 4000)
    apb(1'b1, `MRS_OFS_CTRL, 32'h4);
    apb(1'b1, sa(0, 0), 32'd500);
    go(5'h01);
    `WAITC("pn_on", motor_on === 1'b1, 400)
    `WAITC("pn_spd", speed_cmd === 16'd500, 2000)
    `CHK("pn_ramp", 1'b1, (wk >= 990 && wk <= 1015))
    go(5'h00);
    `WAITC("pn_off", motor_on === 1'b0, 4000)
    // Brake-free pin at standstill
    go(5'h10);
    `WAITC("free_on", brake_release === 1'b1, 300)
    go(5'h00);
    `WAITC("free_off", brake_release === 1'b0, 300)
    stop_test();
  end
endmodule
